// *** two_wire_pkg.sv ***
// Constants, register map and state type of the two-wire serial master.
package two_wire_pkg;

	localparam int ADDR_W = 8;

	localparam logic [ADDR_W-1:0] OFF_CMD    = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_MODE   = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_IADDR  = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_CWGR   = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h20;
	localparam logic [ADDR_W-1:0] OFF_IER    = 8'h24;
	localparam logic [ADDR_W-1:0] OFF_IDR    = 8'h28;
	localparam logic [ADDR_W-1:0] OFF_IMR    = 8'h2C;
	localparam logic [ADDR_W-1:0] OFF_RHR    = 8'h30;
	localparam logic [ADDR_W-1:0] OFF_THR    = 8'h34;

	localparam int CMD_START = 0;
	localparam int CMD_STOP  = 1;
	localparam int CMD_MASTER_ENABLE_CMD  = 2;
	localparam int CMD_MASTER_DISABLE_CMD = 3;
	localparam int CMD_SOFT_RESET_CMD = 7;

	localparam int MODE_SLAVE_DEVICE_ADDR_LSB = 16;
	localparam int MODE_SLAVE_DEVICE_ADDR_MSB = 22;
	localparam int MODE_READ     = 12;
	localparam int MODE_IASZ_LSB = 8;
	localparam int MODE_IASZ_MSB = 9;
	localparam logic [31:0] MODE_MASK  = 32'h007F_1300;
	localparam logic [31:0] IADDR_MASK = 32'h00FF_FFFF;

	localparam int SR_RX_READY_FLAG  = 1;
	localparam int SR_TX_READY_FLAG  = 2;
	localparam int SR_TX_COMPLETE_FLAG = 3;
	localparam int SR_NACK   = 8;

	localparam int DIV_MSB = 7;

	localparam logic [1:0] KIND_ADDR  = 2'h0;
	localparam logic [1:0] KIND_IADDR = 2'h1;
	localparam logic [1:0] KIND_DATA  = 2'h2;

	localparam logic [1:0] PH_SET  = 2'h0;
	localparam logic [1:0] PH_HIGH = 2'h1;
	localparam logic [1:0] PH_END  = 2'h2;
	localparam logic [1:0] PH_LOW  = 2'h3;

	localparam logic [2:0] BIT_LAST = 3'h7;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_START = 3'b001,
		ST_SEND  = 3'b010,
		ST_RACK  = 3'b011,
		ST_RECV  = 3'b100,
		ST_MACK  = 3'b101,
		ST_STOP  = 3'b110
	} fsm_t;

	typedef struct packed {
		fsm_t        st;
		logic [1:0]  half;
		logic [7:0]  div;
		logic [7:0]  shift;
		logic [2:0]  bits;
		logic [1:0]  kind;
		logic [1:0]  addr_left;
		logic        rd_phase;
		logic        last_rx;
		logic        start_req;
		logic        stop_req;
		logic        dis_pend;
		logic        master_on;
		logic [31:0] mode;
		logic [23:0] internal_addr;
		logic [31:0] cwgr;
		logic [31:0] imr;
		logic [7:0]  thr;
		logic        thr_full;
		logic [7:0]  rhr;
		logic        tx_complete_flag;
		logic        rx_ready_flag;
		logic        tx_ready_flag;
		logic        nack;
		logic        scl_oe;
		logic        sda_oe;
		logic        sda_m;
		logic        sda_s;
		logic        scl_m;
		logic        scl_s;
		logic [31:0] prdata;
		logic        pslverr;
	} state_t;

	localparam state_t STATE_RST = '{st: ST_IDLE, tx_complete_flag: 1'b1, default: '0};

endpackage

// *** two_wire_master_regs.sv ***
// Two-wire serial master with its APB register file.
//
// Contract
// - START command bit launches a frame
// - Transmit holding write launches a write frame
// - STOP command ends read after current byte
// - Read NACK from slave forces a stop
// - Write stops when holding and shifter empty
// - Master enable works only without disable
// - Master disable waits until write data drains
// - Disable during read finishes current byte
// - Software reset equals system reset
// - Internal address size selects zero to three bytes
// - Direction bit selects write or read
// - Device address field sent each frame
// - Start and stop change data while clock high
// - Transmit ready set on ack until next write
// - Receive ready cleared by holding register read
// - Ninth pulse samples ack, sets NACK flag
`timescale 1ns/1ps
module two_wire_master_regs (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        scl_in,
	output logic             scl_out,
	output logic             scl_oe,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe,
	output logic             irq
);

	two_wire_pkg::state_t state_r;
	two_wire_pkg::state_t state_nxt;
	logic        acc;
	logic        wr;
	logic        rd;
	logic        cmd_wr;
	logic        tick;
	logic        stall;
	logic [31:0] sr;
	logic [31:0] rdata;
	logic        hit;
	logic        read_direction;
	logic [1:0]  iasz;
	logic [6:0]  slave_device_addr;

	////////////////////////////////////////////////////////////////////////////////////////
	// Bus decode and read mux.

	assign acc    = psel & penable;
	assign wr     = acc & pwrite;
	assign rd     = acc & ~pwrite;
	assign cmd_wr = wr && paddr == two_wire_pkg::OFF_CMD;
	assign read_direction  = state_r.mode[two_wire_pkg::MODE_READ];
	assign iasz   = state_r.mode[two_wire_pkg::MODE_IASZ_MSB:two_wire_pkg::MODE_IASZ_LSB];
	assign slave_device_addr   = state_r.mode[two_wire_pkg::MODE_SLAVE_DEVICE_ADDR_MSB:two_wire_pkg::MODE_SLAVE_DEVICE_ADDR_LSB];

	always_comb begin
		sr = '0;
		sr[two_wire_pkg::SR_RX_READY_FLAG]  = state_r.rx_ready_flag;
		sr[two_wire_pkg::SR_TX_READY_FLAG]  = state_r.tx_ready_flag;
		sr[two_wire_pkg::SR_TX_COMPLETE_FLAG] = state_r.tx_complete_flag;
		sr[two_wire_pkg::SR_NACK]   = state_r.nack;
	end

	always_comb begin
		rdata = '0;
		hit   = 1'b1;
		unique case (paddr)
			two_wire_pkg::OFF_CMD, two_wire_pkg::OFF_IER, two_wire_pkg::OFF_IDR: rdata = '0;
			two_wire_pkg::OFF_MODE:   rdata = state_r.mode;
			two_wire_pkg::OFF_IADDR:  rdata = {8'h00, state_r.internal_addr};
			two_wire_pkg::OFF_CWGR:   rdata = state_r.cwgr;
			two_wire_pkg::OFF_STATUS: rdata = sr;
			two_wire_pkg::OFF_IMR:    rdata = state_r.imr;
			two_wire_pkg::OFF_RHR:    rdata = {24'h00_0000, state_r.rhr};
			two_wire_pkg::OFF_THR:    rdata = {24'h00_0000, state_r.thr};
			default:                  hit   = 1'b0;
		endcase
	end

	// A released clock line held low by the slave stalls the divider, stretching the low phase.
	assign stall = state_r.st != two_wire_pkg::ST_IDLE && !state_r.scl_oe && !state_r.scl_s;
	assign tick  = state_r.div == '0 && !stall;

	////////////////////////////////////////////////////////////////////////////////////////
	// Next state.

	always_comb begin
		state_nxt = state_r;
		state_nxt.sda_m = sda_in;
		state_nxt.sda_s = state_r.sda_m;
		state_nxt.scl_m = scl_in;
		state_nxt.scl_s = state_r.scl_m;
		// Read data is latched in the setup cycle so prdata comes from a flop.
		if (psel && !penable) begin
			state_nxt.prdata  = rdata;
			state_nxt.pslverr = ~hit;
		end

		// Software clears come first so that hardware sets below win.
		if (wr) begin
			unique case (paddr)
				two_wire_pkg::OFF_CMD: begin
					if (pwdata[two_wire_pkg::CMD_START]) begin
						state_nxt.start_req = 1'b1;
					end
					if (pwdata[two_wire_pkg::CMD_STOP]) begin
						state_nxt.stop_req = 1'b1;
					end
					if (pwdata[two_wire_pkg::CMD_MASTER_DISABLE_CMD]) begin
						state_nxt.dis_pend = 1'b1;
					end else if (pwdata[two_wire_pkg::CMD_MASTER_ENABLE_CMD]) begin
						state_nxt.master_on = 1'b1;
						state_nxt.dis_pend  = 1'b0;
					end
				end
				two_wire_pkg::OFF_MODE:  state_nxt.mode = pwdata & two_wire_pkg::MODE_MASK;
				two_wire_pkg::OFF_IADDR: state_nxt.internal_addr = pwdata[23:0];
				two_wire_pkg::OFF_CWGR:  state_nxt.cwgr = pwdata;
				two_wire_pkg::OFF_IER:   state_nxt.imr = state_r.imr | pwdata;
				two_wire_pkg::OFF_IDR:   state_nxt.imr = state_r.imr & ~pwdata;
				two_wire_pkg::OFF_THR: begin
					state_nxt.thr           = pwdata[7:0];
					state_nxt.thr_full      = 1'b1;
					state_nxt.tx_ready_flag = 1'b0;
				end
				default: ;
			endcase
		end
		if (rd && paddr == two_wire_pkg::OFF_RHR) begin
			state_nxt.rx_ready_flag = 1'b0;
		end

		if (state_r.st != two_wire_pkg::ST_IDLE) begin
			if (tick) begin
				state_nxt.div = state_r.cwgr[two_wire_pkg::DIV_MSB:0];
			end else if (!stall) begin
				state_nxt.div = state_r.div - 8'h01;
			end
		end

		unique case (state_r.st)
			two_wire_pkg::ST_IDLE: begin
				state_nxt.scl_oe = 1'b0;
				state_nxt.sda_oe = 1'b0;
				state_nxt.div    = '0;
				if (state_r.master_on && (state_r.start_req || (!read_direction && state_r.thr_full))) begin
					state_nxt.st               = two_wire_pkg::ST_START;
					state_nxt.half             = two_wire_pkg::PH_SET;
					state_nxt.start_req        = 1'b0;
					state_nxt.tx_complete_flag = 1'b0;
					state_nxt.nack             = 1'b0;
					state_nxt.addr_left        = iasz;
					state_nxt.rd_phase         = read_direction && iasz == '0;
				end else if (state_r.dis_pend && !state_r.thr_full) begin
					state_nxt.master_on = 1'b0;
					state_nxt.dis_pend  = 1'b0;
				end
			end
			two_wire_pkg::ST_START: if (tick) begin
				state_nxt.half = state_r.half + 2'h1;
				unique case (state_r.half)
					two_wire_pkg::PH_SET:  state_nxt.sda_oe = 1'b0;
					two_wire_pkg::PH_HIGH: state_nxt.scl_oe = 1'b0;
					two_wire_pkg::PH_END:  state_nxt.sda_oe = 1'b1;
					two_wire_pkg::PH_LOW: begin
						state_nxt.scl_oe = 1'b1;
						state_nxt.shift  = {slave_device_addr, state_r.rd_phase};
						state_nxt.kind   = two_wire_pkg::KIND_ADDR;
						state_nxt.bits   = two_wire_pkg::BIT_LAST;
						state_nxt.half   = two_wire_pkg::PH_SET;
						state_nxt.st     = two_wire_pkg::ST_SEND;
					end
				endcase
			end
			two_wire_pkg::ST_SEND, two_wire_pkg::ST_RACK,
			two_wire_pkg::ST_RECV, two_wire_pkg::ST_MACK: if (tick) begin
				unique case (state_r.half)
					two_wire_pkg::PH_SET: begin
						state_nxt.half = two_wire_pkg::PH_HIGH;
						unique case (state_r.st)
							two_wire_pkg::ST_SEND: state_nxt.sda_oe = ~state_r.shift[7];
							two_wire_pkg::ST_MACK: state_nxt.sda_oe = ~state_r.last_rx;
							default:               state_nxt.sda_oe = 1'b0;
						endcase
					end
					two_wire_pkg::PH_HIGH: begin
						state_nxt.scl_oe = 1'b0;
						state_nxt.half   = two_wire_pkg::PH_END;
					end
					default: begin
						state_nxt.scl_oe = 1'b1;
						state_nxt.half   = two_wire_pkg::PH_SET;
						unique case (state_r.st)
							two_wire_pkg::ST_SEND: begin
								state_nxt.shift = {state_r.shift[6:0], 1'b0};
								state_nxt.bits  = state_r.bits - 3'h1;
								if (state_r.bits == '0) begin
									state_nxt.st = two_wire_pkg::ST_RACK;
								end
							end
							two_wire_pkg::ST_RACK: begin
								if (state_r.sda_s) begin
									state_nxt.nack = 1'b1;
									state_nxt.st   = two_wire_pkg::ST_STOP;
								end else if (state_r.kind == two_wire_pkg::KIND_ADDR
										&& state_r.rd_phase) begin
									state_nxt.st      = two_wire_pkg::ST_RECV;
									state_nxt.bits    = two_wire_pkg::BIT_LAST;
									state_nxt.last_rx = 1'b0;
								end else if (state_r.addr_left != '0) begin
									unique case (state_r.addr_left)
										2'h3:    state_nxt.shift = state_r.internal_addr[23:16];
										2'h2:    state_nxt.shift = state_r.internal_addr[15:8];
										default: state_nxt.shift = state_r.internal_addr[7:0];
									endcase
									state_nxt.addr_left = state_r.addr_left - 2'h1;
									state_nxt.kind      = two_wire_pkg::KIND_IADDR;
									state_nxt.bits      = two_wire_pkg::BIT_LAST;
									state_nxt.st        = two_wire_pkg::ST_SEND;
								end else if (read_direction) begin
									// Internal address sent: repeated start, then read.
									state_nxt.rd_phase = 1'b1;
									state_nxt.st       = two_wire_pkg::ST_START;
								end else begin
									state_nxt.tx_ready_flag = 1'b1;
									if (state_r.thr_full) begin
										state_nxt.shift    = state_r.thr;
										state_nxt.thr_full = 1'b0;
										state_nxt.kind     = two_wire_pkg::KIND_DATA;
										state_nxt.bits     = two_wire_pkg::BIT_LAST;
										state_nxt.st       = two_wire_pkg::ST_SEND;
									end else begin
										state_nxt.st = two_wire_pkg::ST_STOP;
									end
								end
							end
							two_wire_pkg::ST_RECV: begin
								state_nxt.shift = {state_r.shift[6:0], state_r.sda_s};
								state_nxt.bits  = state_r.bits - 3'h1;
								if (state_r.bits == '0) begin
									state_nxt.rhr           = {state_r.shift[6:0], state_r.sda_s};
									state_nxt.rx_ready_flag = 1'b1;
									// Stop or disable seen during this byte makes it the last.
									state_nxt.last_rx = state_r.stop_req || state_r.dis_pend;
									state_nxt.st      = two_wire_pkg::ST_MACK;
								end
							end
							default: begin
								state_nxt.bits = two_wire_pkg::BIT_LAST;
								state_nxt.st   = state_r.last_rx ? two_wire_pkg::ST_STOP
									: two_wire_pkg::ST_RECV;
							end
						endcase
					end
				endcase
			end
			two_wire_pkg::ST_STOP: if (tick) begin
				unique case (state_r.half)
					two_wire_pkg::PH_SET: begin
						state_nxt.sda_oe = 1'b1;
						state_nxt.half   = two_wire_pkg::PH_HIGH;
					end
					two_wire_pkg::PH_HIGH: begin
						state_nxt.scl_oe = 1'b0;
						state_nxt.half   = two_wire_pkg::PH_END;
					end
					default: begin
						state_nxt.sda_oe           = 1'b0;
						state_nxt.half             = two_wire_pkg::PH_SET;
						state_nxt.tx_complete_flag = 1'b1;
						state_nxt.stop_req         = 1'b0;
						state_nxt.st               = two_wire_pkg::ST_IDLE;
					end
				endcase
			end
			default: state_nxt.st = two_wire_pkg::ST_IDLE;
		endcase

		if (cmd_wr && pwdata[two_wire_pkg::CMD_SOFT_RESET_CMD]) begin
			state_nxt = two_wire_pkg::STATE_RST;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= two_wire_pkg::STATE_RST;
		end else begin
			state_r <= state_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////
	// Outputs. Both lines are open drain, so only the enables ever change.

	assign prdata  = state_r.prdata;
	assign pready  = 1'b1;
	assign pslverr = state_r.pslverr;
	assign scl_out = 1'b0;
	assign sda_out = 1'b0;
	assign scl_oe  = state_r.scl_oe;
	assign sda_oe  = state_r.sda_oe;
	assign irq     = |(sr & state_r.imr);

	////////////////////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	start_cond_a: assert property ((state_r.st == two_wire_pkg::ST_START
		&& $rose(state_r.sda_oe)) |-> !state_r.scl_oe) else $error("start edge with clock low");
	stop_cond_a: assert property ((state_r.st == two_wire_pkg::ST_IDLE
		&& $fell(state_r.sda_oe)) |-> !state_r.scl_oe) else $error("stop edge with clock low");
	start_cmd_a: assert property ((cmd_wr && pwdata[two_wire_pkg::CMD_START]
		&& !pwdata[two_wire_pkg::CMD_SOFT_RESET_CMD]) |=> (state_r.start_req
		|| state_r.st == two_wire_pkg::ST_START)) else $error("start command lost");
	thr_launch_a: assert property ((state_r.st == two_wire_pkg::ST_IDLE && !read_direction
		&& state_r.master_on && state_r.thr_full && !cmd_wr)
		|=> state_r.st == two_wire_pkg::ST_START) else $error("write frame not launched");
	nack_stop_a: assert property ((state_r.st == two_wire_pkg::ST_RACK && tick
		&& state_r.half == two_wire_pkg::PH_END && state_r.sda_s && !cmd_wr)
		|=> (state_r.st == two_wire_pkg::ST_STOP && state_r.nack)) else $error("nack no stop");
	empty_stop_a: assert property ((state_r.st == two_wire_pkg::ST_RACK && tick
		&& state_r.half == two_wire_pkg::PH_END && !state_r.sda_s && !read_direction
		&& state_r.addr_left == '0 && !state_r.thr_full && !wr)
		|=> state_r.st == two_wire_pkg::ST_STOP) else $error("write did not stop");
	master_enable_cmd_a: assert property ((cmd_wr && pwdata[two_wire_pkg::CMD_MASTER_ENABLE_CMD]
		&& !pwdata[two_wire_pkg::CMD_MASTER_DISABLE_CMD] && !pwdata[two_wire_pkg::CMD_SOFT_RESET_CMD])
		|=> state_r.master_on) else $error("master enable ignored");
	drain_a: assert property ((state_r.master_on && state_r.dis_pend
		&& state_r.thr_full && !cmd_wr)
		|=> state_r.master_on) else $error("disabled before drain");
	soft_reset_cmd_a: assert property ((cmd_wr && pwdata[two_wire_pkg::CMD_SOFT_RESET_CMD])
		|=> (state_r.mode == '0 && state_r.imr == '0 && state_r.tx_complete_flag
		&& state_r.st == two_wire_pkg::ST_IDLE)) else $error("soft reset incomplete");
	rx_ready_flag_clr_a: assert property ((rd && paddr == two_wire_pkg::OFF_RHR
		&& state_r.st != two_wire_pkg::ST_RECV) |=> !state_r.rx_ready_flag)
		else $error("receive ready not cleared");
	tx_ready_flag_clr_a: assert property ((wr && paddr == two_wire_pkg::OFF_THR
		&& state_r.st != two_wire_pkg::ST_RACK) |=> !state_r.tx_ready_flag)
		else $error("transmit ready not cleared");
	mask_set_a: assert property ((wr && paddr == two_wire_pkg::OFF_IER)
		|=> (state_r.imr & $past(pwdata)) == $past(pwdata)) else $error("mask not set");
	irq_nack_a: assert property ((state_r.nack && state_r.imr[two_wire_pkg::SR_NACK])
		|-> irq) else $error("interrupt missing");

	read_done_c: cover property (state_r.st == two_wire_pkg::ST_MACK && state_r.last_rx
		##[1:300] state_r.st == two_wire_pkg::ST_IDLE);
	write_data_c: cover property (state_r.st == two_wire_pkg::ST_SEND
		&& state_r.kind == two_wire_pkg::KIND_DATA);
	nack_c: cover property ($rose(state_r.nack));
	restart_c: cover property (state_r.st == two_wire_pkg::ST_START && state_r.rd_phase
		&& state_r.kind == two_wire_pkg::KIND_IADDR);

endmodule

// *** serial_slave_model.sv ***
// Behavioural slave on the two-wire bus: logs the bytes it takes and answers reads.
`timescale 1ns/1ps
module serial_slave_model (
	input  wire logic       scl,
	input  wire logic       sda,
	input  wire logic       ack_on,
	input  wire logic [7:0] rd_byte,
	output logic            sda_pull
);
	logic [7:0] sh;
	logic [7:0] tx;
	logic [3:0] pos;
	logic       first;
	logic       rd_now;
	logic       rd_next;
	logic [7:0] log_q[$];

	initial begin
		{sh, tx, pos, first, rd_now, rd_next, sda_pull} = '0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// A start or repeated start restarts the byte count.
	always @(negedge sda) begin
		if (scl === 1'b1) begin
			{pos, rd_now, rd_next, sda_pull} = '0;
			first = 1'b1;
		end
	end

	// After a stop the data line is let go, so it floats to the pull-up level.
	always @(posedge sda) begin
		if (scl === 1'b1) begin
			{rd_now, first, sda_pull} = '0;
		end
	end

	always @(posedge scl) begin
		if (pos < 4'd8 && !rd_now) begin
			sh = {sh[6:0], sda};
		end
		// A released line in the ninth pulse of a read marks the last byte.
		if (pos == 4'd8 && rd_now && sda === 1'b1) begin
			rd_now = 1'b0;
		end
		pos = pos + 4'd1;
	end

	// Data only moves while the clock is low, so no false start or stop is made.
	always @(negedge scl) begin
		if (pos == 4'd8) begin
			if (!rd_now) begin
				log_q.push_back(sh);
				if (first) begin
					rd_next = sh[0];
				end
				sda_pull = ack_on;
			end else begin
				tx = tx + 8'h01;
				sda_pull = 1'b0;
			end
		end else if (pos == 4'd9) begin
			pos = 4'd0;
			first = 1'b0;
			if (rd_next && ack_on) begin
				rd_now = 1'b1;
				rd_next = 1'b0;
				tx = rd_byte;
			end
			sda_pull = rd_now & ~tx[7];
		end else if (pos != 4'd0) begin
			sda_pull = rd_now & ~tx[3'(4'd7 - pos)];
		end
	end
endmodule

// *** tb_top.sv ***
// Self-checking testbench of the two-wire master and its register file.
`timescale 1ns/1ps
module tb_top;
	localparam logic [7:0] A_CMD = two_wire_pkg::OFF_CMD;
	localparam logic [7:0] A_MD  = two_wire_pkg::OFF_MODE;
	localparam logic [7:0] A_IA  = two_wire_pkg::OFF_IADDR;
	localparam logic [7:0] A_CW  = two_wire_pkg::OFF_CWGR;
	localparam logic [7:0] A_ST  = two_wire_pkg::OFF_STATUS;
	localparam logic [7:0] A_IER = two_wire_pkg::OFF_IER;
	localparam logic [7:0] A_IDR = two_wire_pkg::OFF_IDR;
	localparam logic [7:0] A_IMR = two_wire_pkg::OFF_IMR;
	localparam logic [7:0] A_RHR = two_wire_pkg::OFF_RHR;
	localparam logic [7:0] A_THR = two_wire_pkg::OFF_THR;
	localparam int         B_RX  = two_wire_pkg::SR_RX_READY_FLAG;
	localparam int         B_TX  = two_wire_pkg::SR_TX_READY_FLAG;
	localparam int         B_TC  = two_wire_pkg::SR_TX_COMPLETE_FLAG;
	localparam int         B_NK  = two_wire_pkg::SR_NACK;

	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        scl_oe;
	logic        sda_oe;
	logic        irq;
	logic        slv_pull;
	logic        ack_on;
	logic [7:0]  rd_byte;
	wire         scl_line;
	wire         sda_line;
	int          n_mismatch;
	int          cmp_count;
	int          cyc;
	logic [31:0] q;
	logic        err;
	logic [7:0]  exp_q[$];

	// Both lines are open drain with pull-ups.
	assign scl_line = scl_oe ? 1'b0 : 1'b1;
	assign sda_line = (sda_oe | slv_pull) ? 1'b0 : 1'b1;

	two_wire_master_regs two_wire_master_regs_i (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.scl_in(scl_line), .scl_out(), .scl_oe(scl_oe), .sda_in(sda_line), .sda_out(),
		.sda_oe(sda_oe), .irq(irq)
	);

	serial_slave_model serial_slave_model_i (
		.scl(scl_line), .sda(sda_line), .ack_on(ack_on), .rd_byte(rd_byte), .sda_pull(slv_pull)
	);

	always #25 pclk = ~pclk;

	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_mismatch++;
			results();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task results();
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// The request is held until pready is seen high at a rising edge.
	task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task wait_sts(input int b);
		int n;
		n = 0;
		q = '0;
		while (q[b] !== 1'b1 && n < 2000) begin
			xfer(1'b0, A_ST, '0);
			n++;
		end
		check("status wait", 32'(q[b]), 32'h0000_0001);
	endtask

	task check_log();
		check("log size", serial_slave_model_i.log_q.size(), exp_q.size());
		foreach (exp_q[i]) check("log byte", 32'(serial_slave_model_i.log_q[i]), 32'(exp_q[i]));
		serial_slave_model_i.log_q.delete();
		exp_q.delete();
	endtask

	function automatic logic [31:0] mode_val(input logic rd, input logic [1:0] sz);
		return {9'h000, 7'h50, 3'h0, rd, 2'h0, sz, 8'h00};
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	task t_reset();
		logic [7:0] offs [7];
		offs = '{A_MD, A_IA, A_CW, A_ST, A_IMR, A_RHR, A_THR};
		foreach (offs[i]) begin
			xfer(1'b0, offs[i], '0);
			check("reset value", q, (offs[i] == A_ST) ? 32'h0000_0008 : 32'h0000_0000);
		end
		xfer(1'b1, A_ST, '0);
		xfer(1'b0, A_ST, '0);
		check("read-only status", q, 32'h0000_0008);
		xfer(1'b0, 8'h08, '0);
		check("unmapped error", 32'(err), 32'h0000_0001);
	endtask

	task t_mask();
		xfer(1'b1, A_IER, 32'h0000_0108);
		xfer(1'b0, A_IMR, '0);
		check("mask set", q, 32'h0000_0108);
		check("irq unmasked", 32'(irq), 32'h0000_0001);
		xfer(1'b1, A_IDR, 32'h0000_0008);
		xfer(1'b0, A_IMR, '0);
		check("mask clear", q, 32'h0000_0100);
		check("irq masked", 32'(irq), 32'h0000_0000);
	endtask

	// Every internal address size, each frame kicked off by the holding write alone.
	task t_write();
		xfer(1'b1, A_CW, 32'h0000_0003);
		xfer(1'b1, A_CMD, 32'h0000_0004);
		for (int sz = 0; sz < 4; sz++) begin
			xfer(1'b1, A_MD, mode_val(1'b0, 2'(sz)));
			xfer(1'b1, A_IA, 32'h0012_3456);
			xfer(1'b1, A_THR, 32'h0000_005A);
			xfer(1'b0, A_ST, '0);
			check("frame started", 32'(q[B_TC]), 32'h0000_0000);
			wait_sts(B_TC);
			exp_q = '{8'hA0};
			for (int k = sz; k > 0; k--) exp_q.push_back(8'(32'h0012_3456 >> (8 * (k - 1))));
			exp_q.push_back(8'h5A);
			check_log();
		end
	endtask

	task t_multi_write();
		xfer(1'b1, A_MD, mode_val(1'b0, 2'h0));
		xfer(1'b1, A_THR, 32'h0000_0011);
		wait_sts(B_TX);
		xfer(1'b1, A_THR, 32'h0000_0022);
		xfer(1'b0, A_ST, '0);
		check("tx ready cleared", 32'(q[B_TX]), 32'h0000_0000);
		wait_sts(B_TC);
		exp_q = '{8'hA0, 8'h11, 8'h22};
		check_log();
	endtask

	task t_read_one();
		xfer(1'b1, A_MD, mode_val(1'b1, 2'h0));
		xfer(1'b1, A_CMD, 32'h0000_0003);
		wait_sts(B_RX);
		xfer(1'b0, A_RHR, '0);
		check("read byte", q, 32'h0000_009C);
		xfer(1'b0, A_ST, '0);
		check("rx ready cleared", 32'(q[B_RX]), 32'h0000_0000);
		wait_sts(B_TC);
		exp_q = '{8'hA1};
		check_log();
	endtask

	task t_read_multi();
		xfer(1'b1, A_MD, mode_val(1'b1, 2'h1));
		xfer(1'b1, A_IA, 32'h0000_0056);
		xfer(1'b1, A_CMD, 32'h0000_0001);
		wait_sts(B_RX);
		xfer(1'b1, A_CMD, 32'h0000_0002);
		xfer(1'b0, A_RHR, '0);
		check("first byte", q, 32'h0000_009C);
		wait_sts(B_RX);
		xfer(1'b0, A_RHR, '0);
		check("second byte", q, 32'h0000_009D);
		wait_sts(B_TC);
		exp_q = '{8'hA0, 8'h56, 8'hA1};
		check_log();
	endtask

	// The slave refuses its address; without a stop command the frame must still end.
	task t_nack();
		@(posedge pclk);
		ack_on <= 1'b0;
		xfer(1'b1, A_MD, mode_val(1'b1, 2'h0));
		xfer(1'b1, A_CMD, 32'h0000_0001);
		wait_sts(B_TC);
		check("nack flag", 32'(q[B_NK]), 32'h0000_0001);
		check("irq on nack", 32'(irq), 32'h0000_0001);
		check("data line idle", 32'(sda_line), 32'h0000_0001);
		exp_q = '{8'hA1};
		check_log();
		@(posedge pclk);
		ack_on <= 1'b1;
	endtask

	task t_disable();
		xfer(1'b1, A_MD, mode_val(1'b0, 2'h0));
		xfer(1'b1, A_THR, 32'h0000_0033);
		xfer(1'b1, A_CMD, 32'h0000_0008);
		wait_sts(B_TC);
		exp_q = '{8'hA0, 8'h33};
		check_log();
		xfer(1'b1, A_THR, 32'h0000_0044);
		xfer(1'b1, A_CMD, 32'h0000_000C);
		repeat (300) @(posedge pclk);
		xfer(1'b0, A_ST, '0);
		check("idle while disabled", 32'(q[B_TC]), 32'h0000_0001);
		check_log();
		xfer(1'b1, A_CMD, 32'h0000_0004);
		wait_sts(B_TX);
		wait_sts(B_TC);
		exp_q = '{8'hA0, 8'h44};
		check_log();
	endtask

	// Disable during a read: the byte in progress still lands and is the last one.
	task t_read_disable();
		xfer(1'b1, A_MD, mode_val(1'b1, 2'h0));
		xfer(1'b1, A_CMD, 32'h0000_0001);
		wait_sts(B_RX);
		xfer(1'b1, A_CMD, 32'h0000_0008);
		xfer(1'b0, A_RHR, '0);
		check("byte before disable", q, 32'h0000_009C);
		wait_sts(B_RX);
		xfer(1'b0, A_RHR, '0);
		check("byte during disable", q, 32'h0000_009D);
		wait_sts(B_TC);
		check("no third byte", 32'(q[B_RX]), 32'h0000_0000);
		exp_q = '{8'hA1};
		check_log();
		xfer(1'b1, A_CMD, 32'h0000_0001);
		repeat (100) @(posedge pclk);
		xfer(1'b0, A_ST, '0);
		check("no frame when disabled", 32'(q[B_TC]), 32'h0000_0001);
		check_log();
	endtask

	task t_soft_reset();
		xfer(1'b1, A_IER, 32'h0000_0004);
		xfer(1'b1, A_MD, mode_val(1'b1, 2'h3));
		check("irq before reset", 32'(irq), 32'h0000_0001);
		xfer(1'b1, A_CMD, 32'h0000_0080);
		xfer(1'b0, A_MD, '0);
		check("mode after reset", q, 32'h0000_0000);
		xfer(1'b0, A_IMR, '0);
		check("mask after reset", q, 32'h0000_0000);
		xfer(1'b0, A_ST, '0);
		check("status after reset", q, 32'h0000_0008);
		check("irq after reset", 32'(irq), 32'h0000_0000);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		ack_on = 1'b1;
		rd_byte = 8'h9C;
		{n_mismatch, cmp_count, cyc} = '0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_mask();
		t_write();
		t_multi_write();
		t_read_one();
		t_read_multi();
		t_nack();
		t_disable();
		t_read_disable();
		t_soft_reset();
		results();
	end
endmodule
